// *** hw/vrc_regs.svh ***
// Register map, field positions and reset values of the vectored request controller.
// Assumes a 32-bit APB slave with word-aligned byte addresses.
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH
`define VRC_OFS_ENABLE_CMD 12'h000
`define VRC_OFS_DISABLE_CMD 12'h004
`define VRC_OFS_CLEAR_CMD 12'h008
`define VRC_OFS_SET_CMD 12'h00c
`define VRC_OFS_EOS_CMD 12'h010
`define VRC_OFS_SPURIOUS 12'h014
`define VRC_OFS_DEBUG 12'h018
`define VRC_OFS_FORCE_EN_CMD 12'h01c
`define VRC_OFS_FORCE_DIS_CMD 12'h020
`define VRC_OFS_MASK 12'h024
`define VRC_OFS_PENDING 12'h028
`define VRC_OFS_FORCE_STAT 12'h02c
`define VRC_OFS_VECTOR 12'h030
`define VRC_OFS_FAST_VECTOR 12'h034
`define VRC_OFS_LINE_STAT 12'h038
`define VRC_OFS_SERVICE 12'h03c
`define VRC_OFS_IRQ_STAT 12'h040
`define VRC_OFS_IRQ_MASK 12'h044
`define VRC_BIT_FAST 0
`define VRC_BIT_PROTECTION_MODE_BIT 0
`define VRC_BIT_GLOBAL_LINE_MASK 1
`define VRC_BIT_NORMAL_LINE 1
`define VRC_BIT_FAST_LINE 0
`define VRC_FORCE_VALID 32'hffff_fffe
`define VRC_RESET_WORD 32'h0000_0000
`define VRC_DEBUG_BITS 2
`define VRC_EV_EOS 0
`define VRC_EV_SET 1
`define VRC_EV_NUM 2
`endif

// *** hw/vrc_pkg.sv ***
// Types shared by the vectored request controller.
// Assumes the register header is included by files that need offsets.
`default_nettype none
package vrc_pkg;
    typedef enum logic [0:0] {
        VRC_IDLE = 1'b0,
        VRC_ACCESS = 1'b1
    } vrc_bus_e;
endpackage
`default_nettype wire

// *** hw/vrc_command_regs.sv ***
// Command and control registers of a vectored interrupt controller, APB slave.
// Assumes ref_clk at 50 MHz, asynchronous active-low resetn, source lines from pins.
// Operation
// - Writing one to an enable command bit enables that source; zeros do nothing
// - Writing one to a disable command bit disables that source; zeros do nothing
// - Writing one to a clear command bit clears that source's request
// - Writing one to a set command bit raises that source's request
// - Bit 0 fast source, bit 1 system source, bits 2 to 31 peripherals
// - Any write to end-of-service location ends current interrupt, data ignored
// - Spurious vector is a 32-bit read-write value returned on spurious reads
// - Debug bit 0 enables protection mode; resets to zero
// - Debug bit 1 holds both processor request lines inactive
// - Writing one to forcing enable bit turns fast forcing on for that source
// - Writing one to forcing disable bit turns fast forcing off for that source
// - Forcing exists only for bits 1 to 31; bit 0 unused
// - Mask register shows enabled state, one means enabled
// - Pending register shows one for each pending request
// - Forcing status register shows one where fast forcing is enabled
// - With no enabled normal request pending the vector read returns the spurious vector
`default_nettype none
`include "vrc_regs.svh"
module vrc_command_regs #(
    parameter int NUM_SRC = 32
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SRC-1:0] sourceLevel,
    output logic normalRequestLine_n,
    output logic fastRequestLine_n,
    output logic protectionMode,
    output logic irq
);

    vrc_pkg::vrc_bus_e busState;
    logic [1:0][NUM_SRC-1:0] srcSync;
    logic [NUM_SRC-1:0] srcPrev;
    logic [NUM_SRC-1:0] enableMask;
    logic [NUM_SRC-1:0] pending;
    logic [NUM_SRC-1:0] forceEnable;
    logic [31:0] spuriousVector;
    logic [`VRC_DEBUG_BITS-1:0] debugControl;
    logic inService;
    logic [4:0] serviceId;
    logic [`VRC_EV_NUM-1:0] evStatus;
    logic [`VRC_EV_NUM-1:0] evMask;
    logic setup;
    logic wrStrobe;
    logic rdStrobe;
    logic [NUM_SRC-1:0] srcRise;
    logic [NUM_SRC-1:0] active;
    logic [NUM_SRC-1:0] fastSet;
    logic [NUM_SRC-1:0] normalSet;
    logic [4:0] lowestId;
    logic decodeHit;
    logic [31:0] next_prdata;
    logic [`VRC_EV_NUM-1:0] evPulse;

    // No wait state: setup cycle, then access phase with pready high
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            busState <= vrc_pkg::VRC_IDLE;
        else if (psel && !penable)
            busState <= vrc_pkg::VRC_ACCESS;
        else
            busState <= vrc_pkg::VRC_IDLE;
    end

    assign setup = psel && !penable;
    // Strobe only on the completing edge so each write takes effect once
    assign wrStrobe = psel && penable && pready && pwrite;
    assign rdStrobe = setup && !pwrite;

    // Source pins cross in from outside the clock domain
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            srcSync <= '0;
            srcPrev <= '0;
        end
        else
        begin
            srcSync[0] <= sourceLevel;
            srcSync[1] <= srcSync[0];
            srcPrev <= srcSync[1];
        end
    end

    assign srcRise = srcSync[1] & ~srcPrev;

    // Enable state per source
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            enableMask <= '0;
        else if (wrStrobe && paddr == `VRC_OFS_ENABLE_CMD)
            enableMask <= enableMask | pwdata[NUM_SRC-1:0];
        else if (wrStrobe && paddr == `VRC_OFS_DISABLE_CMD)
            enableMask <= enableMask & ~pwdata[NUM_SRC-1:0];
    end

    // Pending requests; hardware edges and software set win over clear
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            pending <= '0;
        else
        begin
            logic [NUM_SRC-1:0] clr;
            logic [NUM_SRC-1:0] set;
            clr = '0;
            set = srcRise;
            if (wrStrobe && paddr == `VRC_OFS_CLEAR_CMD)
                clr = pwdata[NUM_SRC-1:0];
            if (wrStrobe && paddr == `VRC_OFS_SET_CMD)
                set = set | pwdata[NUM_SRC-1:0];
            // Reading the vector acknowledges the normal request taken
            if (rdStrobe && paddr == `VRC_OFS_VECTOR && |normalSet)
                clr = clr | (NUM_SRC'(1) << lowestId);
            pending <= (pending & ~clr) | set;
        end
    end

    // Fast forcing state; bit 0 has no storage
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            forceEnable <= '0;
        else if (wrStrobe && paddr == `VRC_OFS_FORCE_EN_CMD)
            forceEnable <= (forceEnable | pwdata[NUM_SRC-1:0]) & `VRC_FORCE_VALID;
        else if (wrStrobe && paddr == `VRC_OFS_FORCE_DIS_CMD)
            forceEnable <= forceEnable & ~pwdata[NUM_SRC-1:0] & `VRC_FORCE_VALID;
    end

    // Spurious vector and debug control
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            spuriousVector <= `VRC_RESET_WORD;
            debugControl <= '0;
        end
        else if (wrStrobe && paddr == `VRC_OFS_SPURIOUS)
            spuriousVector <= pwdata;
        else if (wrStrobe && paddr == `VRC_OFS_DEBUG)
            debugControl <= pwdata[`VRC_DEBUG_BITS-1:0];
    end

    // Fast bit and forced sources go to the fast line, the rest to normal
    assign active = pending & enableMask;
    assign fastSet = active & (forceEnable | (NUM_SRC'(1) << `VRC_BIT_FAST));
    assign normalSet = active & ~fastSet;

    // Lowest numbered normal source is served first; priority lives elsewhere
    always_comb
    begin
        lowestId = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (normalSet[i])
                lowestId = 5'(i);
        end
    end

    // Service tracking: taken on vector read, ended by any end-of-service write
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            inService <= 1'b0;
            serviceId <= '0;
        end
        else if (wrStrobe && paddr == `VRC_OFS_EOS_CMD)
            inService <= 1'b0;
        else if (rdStrobe && paddr == `VRC_OFS_VECTOR && |normalSet)
        begin
            inService <= 1'b1;
            serviceId <= lowestId;
        end
    end

    // Request lines are active low; general mask parks them inactive
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            normalRequestLine_n <= 1'b1;
            fastRequestLine_n <= 1'b1;
            protectionMode <= 1'b0;
        end
        else
        begin
            normalRequestLine_n <= debugControl[`VRC_BIT_GLOBAL_LINE_MASK] || inService
                                   || !(|normalSet);
            fastRequestLine_n <= debugControl[`VRC_BIT_GLOBAL_LINE_MASK] || !(|fastSet);
            protectionMode <= debugControl[`VRC_BIT_PROTECTION_MODE_BIT];
        end
    end

    // Events: end of service seen, software set issued
    assign evPulse[`VRC_EV_EOS] = wrStrobe && paddr == `VRC_OFS_EOS_CMD;
    assign evPulse[`VRC_EV_SET] = wrStrobe && paddr == `VRC_OFS_SET_CMD;

    // Sticky status; a new event beats a write-one clear in the same cycle
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            evStatus <= '0;
            evMask <= '0;
        end
        else
        begin
            if (wrStrobe && paddr == `VRC_OFS_IRQ_STAT)
                evStatus <= (evStatus & ~pwdata[`VRC_EV_NUM-1:0]) | evPulse;
            else
                evStatus <= evStatus | evPulse;
            if (wrStrobe && paddr == `VRC_OFS_IRQ_MASK)
                evMask <= pwdata[`VRC_EV_NUM-1:0];
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            irq <= 1'b0;
        else
            irq <= |(evStatus & evMask);
    end

    // Read mux; command locations read zero and change nothing
    always_comb
    begin
        next_prdata = '0;
        decodeHit = 1'b1;
        case (paddr)
            `VRC_OFS_ENABLE_CMD, `VRC_OFS_DISABLE_CMD, `VRC_OFS_CLEAR_CMD,
            `VRC_OFS_SET_CMD, `VRC_OFS_EOS_CMD, `VRC_OFS_FORCE_EN_CMD,
            `VRC_OFS_FORCE_DIS_CMD: next_prdata = '0;
            `VRC_OFS_SPURIOUS: next_prdata = spuriousVector;
            `VRC_OFS_DEBUG: next_prdata = 32'(debugControl);
            `VRC_OFS_MASK: next_prdata = 32'(enableMask);
            `VRC_OFS_PENDING: next_prdata = 32'(pending);
            `VRC_OFS_FORCE_STAT: next_prdata = 32'(forceEnable);
            `VRC_OFS_VECTOR: next_prdata = |normalSet ? 32'(lowestId)
                                          : spuriousVector;
            `VRC_OFS_FAST_VECTOR: next_prdata = |fastSet ? 32'h0000_0000
                                               : spuriousVector;
            `VRC_OFS_LINE_STAT: next_prdata = 32'({!normalRequestLine_n, !fastRequestLine_n});
            `VRC_OFS_SERVICE: next_prdata = 32'({inService, serviceId});
            `VRC_OFS_IRQ_STAT: next_prdata = 32'(evStatus);
            `VRC_OFS_IRQ_MASK: next_prdata = 32'(evMask);
            default: decodeHit = 1'b0;
        endcase
    end

    // Answer registered during setup so every output comes from a flip-flop
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !decodeHit;
            prdata <= rdStrobe ? next_prdata : '0;
        end
    end

endmodule
`default_nettype wire

// *** verification/vrc_command_regs_props.sv ***
// Port checker for the command register block.
// Assumes it is bound onto vrc_command_regs and sees nothing but its ports.
`default_nettype none
module vrc_command_regs_props #(
    parameter int NUM_SRC = 32
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_SRC-1:0] sourceLevel,
    input wire logic normalRequestLine_n,
    input wire logic fastRequestLine_n,
    input wire logic protectionMode,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic [31:0] spuHeld;
    assign acc = psel && penable && pready;
    // Shadow of the spurious value, so a read can be tied to the last write
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            spuHeld <= 32'h0000_0000;
        else if (acc && pwrite && paddr == 12'h014)
            spuHeld <= pwdata;
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_short; pready |=> !pready; endproperty
    a_short: assert property (p_short) else $error("ready held too long");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("ready without select");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unm; acc && paddr > 12'h044 |-> pslverr; endproperty
    a_unm: assert property (p_unm) else $error("unmapped access not refused");
    property p_cmd;
        acc && !pwrite && (paddr <= 12'h010 || paddr == 12'h01c || paddr == 12'h020)
            |-> prdata == 32'h0000_0000;
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("command location read not zero");
    property p_spu; acc && !pwrite && paddr == 12'h014 |-> prdata == spuHeld; endproperty
    a_spu: assert property (p_spu)
        else $error("spurious value lost");
    // Two cycles allow for a copy register behind the debug bit
    property p_protection_mode_bit;
        acc && pwrite && paddr == 12'h018 |=> ##1 protectionMode == $past(pwdata[0], 2);
    endproperty
    a_protection_mode_bit: assert property (p_protection_mode_bit)
        else $error("protection output wrong");
    property p_global_line_mask;
        acc && pwrite && paddr == 12'h018 && pwdata[1]
            |=> ##1 (normalRequestLine_n && fastRequestLine_n)[*3];
    endproperty
    a_global_line_mask: assert property (p_global_line_mask)
        else $error("line active under general mask");
endmodule
bind vrc_command_regs vrc_command_regs_props #(.NUM_SRC(NUM_SRC)) u_props (
    .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sourceLevel, .normalRequestLine_n, .fastRequestLine_n,
    .protectionMode, .irq
);
`default_nettype wire

// *** verification/vrc_core_model.sv ***
// Stand-in for the processor core that receives the two request lines.
// Assumes the lines are active low and come from ref_clk registers.
`default_nettype none
module vrc_core_model (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic normalRequestLine_n,
    input wire logic fastRequestLine_n,
    output logic normalTaken,
    output logic fastTaken
);
    timeunit 1ns;
    timeprecision 1ps;
    // The core only sees the lines at its own clock edge
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            normalTaken <= 1'b0;
            fastTaken <= 1'b0;
        end
        else
        begin
            normalTaken <= !normalRequestLine_n;
            fastTaken <= !fastRequestLine_n;
        end
    end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench: APB master, read scoreboard and core stand-in.
// Assumes the design, the checker and the core model are compiled first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
    logic normalRequestLine_n, fastRequestLine_n, protectionMode, normalTaken, fastTaken;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, sourceLevel, rnd, en, pend, ff;
    logic [32:0] expQ[$];
    logic [32:0] e;
    logic [11:0] rstA[6] = '{12'h014, 12'h018, 12'h024, 12'h028, 12'h02c, 12'h044};
    logic [11:0] cmdA[7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h01c, 12'h020};
    int n_fail, compares;
    vrc_command_regs #(.NUM_SRC(32)) dut (.ref_clk, .resetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sourceLevel, .normalRequestLine_n,
        .fastRequestLine_n, .protectionMode, .irq);
    vrc_core_model core (.ref_clk, .resetn, .normalRequestLine_n, .fastRequestLine_n,
        .normalTaken, .fastTaken);
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Transfers run back to back; the request is held until pready is seen
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        if (!wr)
            expQ.push_back({a > 12'h044, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wr ? d : 32'h0;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
    endtask
    task automatic pause;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic close_out;
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Scoreboard: each finished read takes the oldest note
    always @(posedge ref_clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e = expQ.pop_front();
            chk("prdata", e[31:0], prdata);
            chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
        end
    end
    initial
    begin
        #100000;
        n_fail++;
        close_out;
    end
    initial
    begin
        {resetn, psel, penable, pwrite, paddr, pwdata, sourceLevel} = '0;
        rnd = 32'd66437;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        foreach (rstA[i]) xfer(0, rstA[i], 32'h0);
        rnd = lfsr(rnd);
        xfer(1, 12'h000, rnd);
        en = rnd;
        xfer(1, 12'h000, 32'h0);
        xfer(0, 12'h024, en);
        rnd = lfsr(rnd);
        xfer(1, 12'h004, rnd);
        en &= ~rnd;
        xfer(0, 12'h024, en);
        rnd = lfsr(rnd);
        xfer(1, 12'h00c, rnd);
        pend = rnd;
        xfer(0, 12'h028, pend);
        rnd = lfsr(rnd);
        xfer(1, 12'h008, rnd);
        pend &= ~rnd;
        xfer(0, 12'h028, pend);
        rnd = lfsr(rnd);
        xfer(1, 12'h01c, rnd);
        ff = rnd & 32'hffff_fffe;
        xfer(0, 12'h02c, ff);
        rnd = lfsr(rnd);
        xfer(1, 12'h020, rnd);
        ff &= ~rnd;
        xfer(0, 12'h02c, ff);
        foreach (cmdA[i]) xfer(0, cmdA[i], 32'h0);
        xfer(0, 12'h024, en);
        xfer(0, 12'h028, pend);
        xfer(0, 12'h100, 32'h0);
        rnd = lfsr(rnd);
        xfer(1, 12'h014, rnd);
        xfer(1, 12'h004, 32'hffff_ffff);
        xfer(1, 12'h008, 32'hffff_ffff);
        xfer(1, 12'h020, 32'hffff_ffff);
        xfer(0, 12'h030, rnd);
        xfer(0, 12'h034, rnd);
        xfer(1, 12'h018, 32'h3);
        xfer(0, 12'h018, 32'h3);
        xfer(1, 12'h000, 32'h5);
        xfer(1, 12'h00c, 32'h5);
        pend = 32'h5;
        pause;
        chk("protectionMode", 32'h1, {31'h0, protectionMode});
        xfer(0, 12'h038, 32'h0);
        xfer(1, 12'h018, 32'h0);
        pause;
        xfer(0, 12'h038, 32'h3);
        pause;
        chk("core", 32'h3, {30'h0, normalTaken, fastTaken});
        sourceLevel <= 32'h0000_0080;
        pause;
        xfer(0, 12'h028, pend | 32'h80);
        xfer(1, 12'h040, 32'h3);
        xfer(0, 12'h040, 32'h0);
        rnd = lfsr(rnd);
        xfer(1, 12'h010, rnd);
        xfer(0, 12'h040, 32'h1);
        xfer(1, 12'h044, 32'h1);
        pause;
        chk("irq", 32'h1, {31'h0, irq});
        xfer(1, 12'h040, 32'h1);
        pause;
        chk("irq", 32'h0, {31'h0, irq});
        close_out;
    end
endmodule
`default_nettype wire
